/* File: bench/testbench.sv */
/* Testbench of wmpd_top: registers, wake modes, thermal, battery, power-down.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
module testbench;
  localparam [3:0]  OVER_IMG  = 4'h3; // programmed image for this run
  localparam [3:0]  UNDER_IMG = 4'h5;
  localparam [3:0]  ON        = 4'h6;
  localparam [27:0] DLY       = 28'h28; // short off delay keeps the run brief
  reg        clk    = 1'b0;
  reg        rst    = 1'b1;
  reg        wake   = 1'b0;
  reg        batt   = 1'b1;
  reg        hot    = 1'b0;
  reg        shut_n = 1'b1;
  wire       scl, sda, sda_out, sda_oe, rail, draw;
  reg [7:0]  rv;
  reg [23:0] rows [0:5];
  integer    n_fail = 0;
  integer    n_tests = 0;
  always #4 clk = ~clk;
  wmpd_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  wmpd_top #(.OTP_BATT_OVER(OVER_IMG), .OTP_BATT_UNDER(UNDER_IMG), .OTP_WAKE_ON(ON),
    .OTP_PD_DIS(1'b1), .OFF_DELAY_CYC(DLY)) u_dut (
    .MCLK(clk), .RESET(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .WAKE_SENSE_INPUT(wake), .BATTERY_SUPPLY_INPUT(batt),
    .OVER_TEMP(hot), .SHUTDOWN_OUTPUT_N(shut_n), .REGULATOR_RAIL_EN(rail),
    .BATTERY_DRAW_EN(draw));
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string what, input [7:0] exp, input [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task pw(input b);
    chk("power", {7'h00, b}, {7'h00, rail});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence: table of register cases, then hand-made power cases
  initial begin
    rows[0] = {8'h01, 8'hFF, 8'h0F};
    rows[1] = {8'h02, 8'hA5, 8'h05};
    rows[2] = {8'h03, 8'h3C, 8'h0C};
    rows[3] = {8'h18, 8'hFF, 8'h08};
    rows[4] = {8'h17, 8'h00, 8'h00};
    rows[5] = {8'h30, 8'h77, 8'h00};
    wt(5);
    rst = 1'b0;
    wt(4);
    pw(1'b0);
    for (int i = 1; i < 4; i++) begin
      u_host.rd(8'(i), rv);
      chk("image", {4'h0, i == 1 ? OVER_IMG : i == 2 ? UNDER_IMG : ON}, rv);
    end
    wake = 1'b1;
    wt(8);
    pw(1'b1);
    for (int i = 0; i < 6; i++) begin
      u_host.wr(rows[i][23:16], rows[i][15:8]);
      u_host.rd(rows[i][23:16], rv);
      chk("register", rows[i][7:0], rv);
    end
    // default mode; a brief shutdown release restarts the off count
    wake = 1'b0;
    shut_n = 1'b0;
    wt(30);
    shut_n = 1'b1;
    wt(1);
    shut_n = 1'b0;
    wt(35);
    pw(1'b1);
    wt(15);
    pw(1'b0);
    wake = 1'b1;
    wt(8);
    u_host.rd(8'h01, rv);
    chk("reload", {4'h0, OVER_IMG}, rv);
    u_host.wr(8'h04, 8'h09);
    wake = 1'b0;
    wt(120);
    pw(1'b1);
    // status: powered and rising-edge mode, no thermal, no off timer
    u_host.rd(8'h1F, rv);
    chk("status", 8'h03, rv);
    hot = 1'b1;
    wt(8);
    chk("draw", 8'h00, {7'h00, draw});
    hot = 1'b0;
    wt(8);
    pw(1'b1);
    // request while disabled is held until the disable bit clears
    u_host.wr(8'h17, 8'h01);
    wt(8);
    pw(1'b1);
    u_host.wr(8'h18, 8'h00);
    wt(8);
    pw(1'b0);
    wake = 1'b1;
    wt(8);
    pw(1'b1);
    u_host.wr(8'h18, 8'h00);
    u_host.wr(8'h17, 8'h01);
    wt(4);
    pw(1'b0);
    u_host.rd(8'h17, rv);
    chk("request", 8'h00, rv);
    wake = 1'b0;
    wt(4);
    wake = 1'b1;
    wt(8);
    pw(1'b1);
    batt = 1'b0;
    wt(8);
    pw(1'b0);
    // mid-run reset restores the image; battery stays off so no reload hides it
    u_host.wr(8'h02, 8'h0A);
    rst = 1'b1;
    wt(5);
    rst = 1'b0;
    wt(4);
    pw(1'b0);
    u_host.rd(8'h02, rv);
    chk("reset image", {4'h0, UNDER_IMG}, rv);
    chk("nak", 8'h00, {7'h00, u_host.nak});
    chk("sda drive", 8'h00, {7'h00, sda_out});
    end_of_test;
  end
  // the run needs about 11k clocks; a hang stops well past that
  initial begin
    wt(40000);
    n_fail++;
    end_of_test;
  end
endmodule // testbench

/* File: bench/wmpd_host.sv */
/* Host model: serial bus master doing single-register writes and reads.
   Assumes an open-drain data line with pull-up, slave pulls via sda_oe. */
`timescale 1ns/1ps
module wmpd_host #(
  parameter [6:0] DEV = 7'h2C
) (
  input  wire clk,
  input  wire sda_oe,
  output reg  scl,
  output wire sda
);
  reg drv_low;
  reg nak;
  // wired-and with pull-up, so a released line reads high
  assign sda = (drv_low | sda_oe) ? 1'b0 : 1'b1;
  initial {scl, drv_low, nak} = 3'b100;
  // six clocks per step keeps both clock phases over four cycles
  task q;
    repeat (6) @(negedge clk);
  endtask
  // one bit out; sending 1 releases the line so the slave may answer
  task bt(input b, output r);
    drv_low = ~b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    scl = 1'b0;
  endtask
  task by(input [7:0] d, input rd, output [7:0] r);
    reg a;
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(1'b1, a);
    if (!rd) nak = nak | a;
  endtask
  // start when st is 1, stop otherwise
  task cond(input st);
    drv_low = ~st;
    q;
    scl = 1'b1;
    q;
    drv_low = st;
    q;
    scl = ~st;
  endtask
  task wr(input [7:0] r, input [7:0] d);
    reg [7:0] x;
    cond(1'b1);
    by({DEV, 1'b0}, 1'b0, x);
    by(r, 1'b0, x);
    by(d, 1'b0, x);
    cond(1'b0);
  endtask
  task rd(input [7:0] r, output [7:0] d);
    reg [7:0] x;
    cond(1'b1);
    by({DEV, 1'b0}, 1'b0, x);
    by(r, 1'b0, x);
    cond(1'b1);
    by({DEV, 1'b1}, 1'b0, x);
    by(8'hFF, 1'b1, d);
    cond(1'b0);
  endtask
endmodule // wmpd_host

/* File: bench/wmpd_top_sva.sv */
/* Checker of wmpd_top: power state and serial ack timing at its ports.
   Assumes it is bound to wmpd_top and that inputs hold >=6 clocks. */
`timescale 1ns/1ps
module wmpd_top_sva (
  input wire MCLK,
  input wire RESET,
  input wire SCL,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire WAKE_SENSE_INPUT,
  input wire BATTERY_SUPPLY_INPUT,
  input wire OVER_TEMP,
  input wire SHUTDOWN_OUTPUT_N,
  input wire REGULATOR_RAIL_EN,
  input wire BATTERY_DRAW_EN
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // levels held long enough to clear the two-flop synchronizers
  sequence s_hot;
    (OVER_TEMP && BATTERY_SUPPLY_INPUT)[*5];
  endsequence
  sequence s_cool;
    (!OVER_TEMP && BATTERY_SUPPLY_INPUT)[*6];
  endsequence
  sequence s_wake;
    (WAKE_SENSE_INPUT && !OVER_TEMP && BATTERY_SUPPLY_INPUT)[*6];
  endsequence
  property p_rst_off;
    $fell(RESET) |-> !REGULATOR_RAIL_EN && !SDA_OE;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("powered after reset");
  property p_pair;
    BATTERY_DRAW_EN == REGULATOR_RAIL_EN;
  endproperty
  a_pair: assert property (p_pair)
    else $error("draw and rail enables differ");
  property p_hot_off;
    s_hot |-> !BATTERY_DRAW_EN;
  endproperty
  a_hot_off: assert property (p_hot_off)
    else $error("battery draw while hot");
  property p_resume;
    REGULATOR_RAIL_EN ##1 s_hot ##1 s_cool |-> REGULATOR_RAIL_EN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after cooling");
  property p_batt_off;
    !BATTERY_SUPPLY_INPUT[*5] |-> !REGULATOR_RAIL_EN;
  endproperty
  a_batt_off: assert property (p_batt_off)
    else $error("powered without battery");
  property p_on_cause;
    $rose(REGULATOR_RAIL_EN) |-> BATTERY_SUPPLY_INPUT && !$past(OVER_TEMP);
  endproperty
  a_on_cause: assert property (p_on_cause)
    else $error("power-on while hot or unpowered");
  property p_wake_on;
    $rose(WAKE_SENSE_INPUT) ##0 s_wake |-> REGULATOR_RAIL_EN;
  endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("no power-on after wake edge");
  // slave may move the data line only while the clock is low
  property p_ack_low;
    $changed(SDA_OE) |-> !SCL;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data line moved with clock high");
  // the data pin only ever pulls low; the enable alone decides its level
  property p_od_low;
    SDA_OE |-> !SDA_OUT;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("data pin driven high");
endmodule // wmpd_top_sva
bind wmpd_top wmpd_top_sva u_sva (
  .MCLK(MCLK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .WAKE_SENSE_INPUT(WAKE_SENSE_INPUT),
  .BATTERY_SUPPLY_INPUT(BATTERY_SUPPLY_INPUT), .OVER_TEMP(OVER_TEMP),
  .SHUTDOWN_OUTPUT_N(SHUTDOWN_OUTPUT_N), .REGULATOR_RAIL_EN(REGULATOR_RAIL_EN),
  .BATTERY_DRAW_EN(BATTERY_DRAW_EN));

/* File: hw/wmpd_i2c_slave.v */
/*
 * Two-wire serial register slave: device address, register pointer, then
 * data bytes written to or read from the one addressed register.
 * Assumes SCL and SDA arrive asynchronously; both pass two flip-flops here.
 */
`timescale 1ns/1ps
`include "wmpd_regs.vh"

module wmpd_i2c_slave #(
  parameter [6:0] DEV_ADDR = `WMPD_DEV_ADDR
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       scl,
  input  wire       sda_in,
  input  wire [7:0] rd_data,
  output reg        sda_oe_ff,
  output reg  [7:0] ptr_ff,
  output reg        wr_stb_ff,
  output reg  [7:0] wr_data_ff
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_DEV   = 4'h1;
  localparam [3:0] S_ADEV  = 4'h2;
  localparam [3:0] S_REG   = 4'h3;
  localparam [3:0] S_AREG  = 4'h4;
  localparam [3:0] S_WDAT  = 4'h5;
  localparam [3:0] S_AWDAT = 4'h6;
  localparam [3:0] S_RDAT  = 4'h7;
  localparam [3:0] S_MACK  = 4'h8;

  reg [2:0] scl_sync_ff;
  reg [2:0] sda_sync_ff;
  reg [3:0] state_ff;
  reg [2:0] cnt_ff;
  reg [7:0] sh_ff;
  reg [7:0] tx_ff;
  reg       rw_ff;
  reg       ack_on_ff;

  wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  wire start    = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
  wire stop     = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];
  wire [7:0] byte_in = {sh_ff[6:0], sda_sync_ff[1]};

  // two-stage synchronisers; stage 2 feeds a third for edge detection
  always @(posedge clk) begin
    if (rst) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end

  // protocol engine; ack is driven on the fall after bit 8, dropped on the next
  always @(posedge clk) begin
    if (rst) begin
      state_ff   <= S_IDLE;
      cnt_ff     <= 3'h0;
      sh_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      rw_ff      <= 1'b0;
      ack_on_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
      ptr_ff     <= 8'h00;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (start) begin
        state_ff  <= S_DEV;
        cnt_ff    <= 3'h0;
        ack_on_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (stop) begin
        state_ff  <= S_IDLE;
        ack_on_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        case (state_ff)
          S_DEV, S_REG, S_WDAT: begin
            sh_ff  <= byte_in;
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              if (state_ff == S_DEV) begin
                rw_ff    <= byte_in[0];
                state_ff <= (byte_in[7:1] == DEV_ADDR) ? S_ADEV : S_IDLE;
              end else if (state_ff == S_REG) begin
                ptr_ff   <= byte_in; // one pointer serves read and write
                state_ff <= S_AREG;
              end else begin
                wr_data_ff <= byte_in;
                wr_stb_ff  <= 1'b1;
                state_ff   <= S_AWDAT;
              end
            end
          end
          S_RDAT: begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              state_ff <= S_MACK;
            end
          end
          S_MACK: begin
            // master nack ends the read; ack asks for the register again
            state_ff <= sda_sync_ff[1] ? S_IDLE : S_RDAT;
            cnt_ff   <= 3'h0;
          end
          default: begin
            state_ff <= state_ff;
          end
        endcase
      end else if (scl_fall) begin
        case (state_ff)
          S_ADEV, S_AREG, S_AWDAT: begin
            if (!ack_on_ff) begin
              ack_on_ff <= 1'b1;
              sda_oe_ff <= 1'b1;
            end else begin
              ack_on_ff <= 1'b0;
              cnt_ff    <= 3'h0;
              if (state_ff == S_ADEV && rw_ff) begin
                state_ff  <= S_RDAT;
                tx_ff     <= rd_data;
                sda_oe_ff <= ~rd_data[7];
              end else begin
                state_ff  <= (state_ff == S_ADEV) ? S_REG : S_WDAT;
                sda_oe_ff <= 1'b0;
              end
            end
          end
          S_RDAT: begin
            if (cnt_ff == 3'h0) begin
              tx_ff     <= rd_data;
              sda_oe_ff <= ~rd_data[7];
            end else begin
              sda_oe_ff <= ~tx_ff[3'h7 - cnt_ff];
            end
          end
          S_MACK: begin
            sda_oe_ff <= 1'b0;
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // wmpd_i2c_slave

/* File: hw/wmpd_regs.vh */
/*
 * Register map, field positions, reset values and timing constants of the
 * wake-mode power-down controller.
 * Assumes a byte-wide register space reached over a two-wire serial slave.
 */
`ifndef WMPD_REGS_VH
`define WMPD_REGS_VH

// register addresses
`define WMPD_ADDR_BATT_OVER   8'h01
`define WMPD_ADDR_BATT_UNDER  8'h02
`define WMPD_ADDR_WAKE_ON     8'h03
`define WMPD_ADDR_WAKE_OFF    8'h04
`define WMPD_ADDR_PD_REQ      8'h17
`define WMPD_ADDR_PD_CFG      8'h18
`define WMPD_ADDR_STATUS      8'h1F

// field layout
`define WMPD_THR_MSB          3
`define WMPD_PD_REQ_BIT       0
`define WMPD_PD_DIS_BIT       3
`define WMPD_ST_POWERED_BIT   0
`define WMPD_ST_RISE_BIT      1
`define WMPD_ST_THERMAL_BIT   2
`define WMPD_ST_TIMING_BIT    3

// reset and unprogrammed values
`define WMPD_THR_RESET        4'h0
`define WMPD_PD_DIS_RESET     1'b0
`define WMPD_READ_ZERO        8'h00

// off-threshold code that selects rising-edge wake-up
`define WMPD_RISE_MODE_CODE   4'h9

// default bus address of the slave
`define WMPD_DEV_ADDR         7'h2C

// timing: off delay in seconds, clock in hertz, and their product in cycles
`define WMPD_OFF_DELAY_S      2
`define WMPD_CLK_HZ           125000000
`define WMPD_CNT_W            28
// sized so the default fits the counter without a silent truncation
`define WMPD_OFF_DELAY_CYC    28'hEE6B280

`endif

/* File: hw/wmpd_top.v */
/*
 * Wake-mode power-down controller: threshold registers, wake-mode select,
 * software power-down, thermal shutdown and the default off delay.
 * Assumes analog comparators deliver the wake, battery and thermal levels
 * as asynchronous digital inputs; the serial bus is open drain, external pull-up.
 */
// Contract
// - rising-edge mode stays on when wake falls
// - off-threshold code 1001 selects rising-edge mode
// - rising-edge mode: off only by command/battery
// - enable bit 0 permits, 1 blocks command
// - request bit 1 powers down when permitted
// - over-temperature shuts down, resumes when clear
// - each register has one read/write address
// - registers load from programmed image at power-up
// - overvoltage threshold four bits, reset zero
// - undervoltage threshold four bits, reset zero
// - turn-on threshold four bits, reset zero
// - default mode: off 2 s after shutdown
`timescale 1ns/1ps
`include "wmpd_regs.vh"

module wmpd_top #(
  parameter [6:0]              DEV_ADDR      = `WMPD_DEV_ADDR,
  parameter [3:0]              OTP_BATT_OVER  = `WMPD_THR_RESET,
  parameter [3:0]              OTP_BATT_UNDER = `WMPD_THR_RESET,
  parameter [3:0]              OTP_WAKE_ON   = `WMPD_THR_RESET,
  parameter [3:0]              OTP_WAKE_OFF  = `WMPD_THR_RESET,
  parameter                    OTP_PD_DIS    = `WMPD_PD_DIS_RESET,
  parameter [`WMPD_CNT_W-1:0]  OFF_DELAY_CYC = `WMPD_OFF_DELAY_CYC
) (
  input  wire MCLK,
  input  wire RESET,
  input  wire SCL,
  input  wire SDA_IN,
  output reg  SDA_OUT,
  output wire SDA_OE,
  input  wire WAKE_SENSE_INPUT,
  input  wire BATTERY_SUPPLY_INPUT,
  input  wire OVER_TEMP,
  input  wire SHUTDOWN_OUTPUT_N,
  output reg  REGULATOR_RAIL_EN,
  output reg  BATTERY_DRAW_EN
);

  localparam [1:0] P_OFF     = 2'h0;
  localparam [1:0] P_ON      = 2'h1;
  localparam [1:0] P_THERMAL = 2'h2;

  reg  [3:0]             sync1_ff;
  reg  [3:0]             sync2_ff;
  reg                    wake_d_ff;
  reg  [1:0]             pstate_ff;
  reg  [1:0]             nxt_pstate;
  reg  [`WMPD_CNT_W-1:0] off_cnt_ff;
  reg  [`WMPD_CNT_W-1:0] nxt_off_cnt;
  reg  [3:0]             batt_over_ff;
  reg  [3:0]             batt_under_ff;
  reg  [3:0]             wake_on_ff;
  reg  [3:0]             wake_off_ff;
  reg                    pd_req_ff;
  reg                    pd_dis_ff;
  reg  [7:0]             rd_data;
  reg                    sw_pd;
  reg                    load_otp;

  wire [7:0] ptr;
  wire       wr_stb;
  wire [7:0] wr_data;

  wire wake      = sync2_ff[0];
  wire batt_ok   = sync2_ff[1];
  wire hot       = sync2_ff[2];
  wire shut_n    = sync2_ff[3];
  wire wake_rise = wake & ~wake_d_ff;
  wire rise_mode = (wake_off_ff == `WMPD_RISE_MODE_CODE);

  // widens a threshold code to a byte with reserved bits zero
  function [7:0] thr_byte;
    input [3:0] code;
    begin
      thr_byte = {4'h0, code};
    end
  endfunction

  // serial register slave; pointer and strobe are shared by all registers
  wmpd_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk        (MCLK),
    .rst        (RESET),
    .scl        (SCL),
    .sda_in     (SDA_IN),
    .rd_data    (rd_data),
    .sda_oe_ff  (SDA_OE),
    .ptr_ff     (ptr),
    .wr_stb_ff  (wr_stb),
    .wr_data_ff (wr_data)
  );

  // comparator levels are asynchronous, so two flops before any use
  always @(posedge MCLK) begin
    if (RESET) begin
      sync1_ff  <= 4'h0;
      sync2_ff  <= 4'h0;
      wake_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= {SHUTDOWN_OUTPUT_N, OVER_TEMP, BATTERY_SUPPLY_INPUT, WAKE_SENSE_INPUT};
      sync2_ff  <= sync1_ff;
      wake_d_ff <= sync2_ff[0];
    end
  end

  // read mux on the same address as writes; unmapped addresses read zero
  always @* begin
    if (ptr == `WMPD_ADDR_BATT_OVER) begin
      rd_data = thr_byte(batt_over_ff);
    end else if (ptr == `WMPD_ADDR_BATT_UNDER) begin
      rd_data = thr_byte(batt_under_ff);
    end else if (ptr == `WMPD_ADDR_WAKE_ON) begin
      rd_data = thr_byte(wake_on_ff);
    end else if (ptr == `WMPD_ADDR_WAKE_OFF) begin
      rd_data = thr_byte(wake_off_ff);
    end else if (ptr == `WMPD_ADDR_PD_REQ) begin
      rd_data = `WMPD_READ_ZERO;
      rd_data[`WMPD_PD_REQ_BIT] = pd_req_ff;
    end else if (ptr == `WMPD_ADDR_PD_CFG) begin
      rd_data = `WMPD_READ_ZERO;
      rd_data[`WMPD_PD_DIS_BIT] = pd_dis_ff;
    end else if (ptr == `WMPD_ADDR_STATUS) begin
      rd_data = `WMPD_READ_ZERO;
      rd_data[`WMPD_ST_POWERED_BIT] = (pstate_ff == P_ON);
      rd_data[`WMPD_ST_RISE_BIT]    = rise_mode;
      rd_data[`WMPD_ST_THERMAL_BIT] = (pstate_ff == P_THERMAL);
      rd_data[`WMPD_ST_TIMING_BIT]  = (off_cnt_ff != {`WMPD_CNT_W{1'b0}});
    end else begin
      rd_data = `WMPD_READ_ZERO;
    end
  end

  // register file; the programmed image is reloaded at every wake-up
  always @(posedge MCLK) begin
    if (RESET || load_otp) begin
      batt_over_ff  <= OTP_BATT_OVER;
      batt_under_ff <= OTP_BATT_UNDER;
      wake_on_ff  <= OTP_WAKE_ON;
      wake_off_ff <= OTP_WAKE_OFF;
      pd_dis_ff   <= OTP_PD_DIS;
      pd_req_ff   <= 1'b0;
    end else if (sw_pd) begin
      // request is consumed as the part goes down
      pd_req_ff <= 1'b0;
    end else if (wr_stb) begin
      if (ptr == `WMPD_ADDR_BATT_OVER) begin
        batt_over_ff <= wr_data[`WMPD_THR_MSB:0];
      end else if (ptr == `WMPD_ADDR_BATT_UNDER) begin
        batt_under_ff <= wr_data[`WMPD_THR_MSB:0];
      end else if (ptr == `WMPD_ADDR_WAKE_ON) begin
        wake_on_ff <= wr_data[`WMPD_THR_MSB:0];
      end else if (ptr == `WMPD_ADDR_WAKE_OFF) begin
        wake_off_ff <= wr_data[`WMPD_THR_MSB:0];
      end else if (ptr == `WMPD_ADDR_PD_REQ) begin
        pd_req_ff <= wr_data[`WMPD_PD_REQ_BIT];
      end else if (ptr == `WMPD_ADDR_PD_CFG) begin
        pd_dis_ff <= wr_data[`WMPD_PD_DIS_BIT];
      end
    end
  end

  // power state: battery loss wins, then heat, then software, then wake
  always @* begin
    nxt_pstate  = pstate_ff;
    nxt_off_cnt = {`WMPD_CNT_W{1'b0}};
    sw_pd       = 1'b0;
    load_otp    = 1'b0;
    case (pstate_ff)
      P_OFF: begin
        if (batt_ok && wake_rise && !hot) begin
          nxt_pstate = P_ON;
          load_otp   = 1'b1;
        end
      end
      P_ON: begin
        if (!batt_ok) begin
          nxt_pstate = P_OFF;
        end else if (hot) begin
          nxt_pstate = P_THERMAL;
        end else if (pd_req_ff && !pd_dis_ff) begin
          // request acts once the disable bit is clear, whichever was written first
          nxt_pstate = P_OFF;
          sw_pd      = 1'b1;
        end else if (!rise_mode && !wake && !shut_n) begin
          // default mode only; rising-edge mode ignores a low wake input
          if (off_cnt_ff == OFF_DELAY_CYC - 1'b1) begin
            nxt_pstate = P_OFF;
          end else begin
            nxt_off_cnt = off_cnt_ff + 1'b1;
          end
        end
      end
      P_THERMAL: begin
        if (!batt_ok) begin
          nxt_pstate = P_OFF;
        end else if (!hot) begin
          nxt_pstate = P_ON;
        end
      end
      default: begin
        nxt_pstate = P_OFF;
      end
    endcase
  end

  // state, off-delay counter and registered outputs
  always @(posedge MCLK) begin
    if (RESET) begin
      pstate_ff         <= P_OFF;
      off_cnt_ff        <= {`WMPD_CNT_W{1'b0}};
      REGULATOR_RAIL_EN <= 1'b0;
      BATTERY_DRAW_EN   <= 1'b0;
      SDA_OUT           <= 1'b0;
    end else begin
      pstate_ff         <= nxt_pstate;
      off_cnt_ff        <= nxt_off_cnt;
      // thermal state cuts battery draw as well as the rail
      REGULATOR_RAIL_EN <= (nxt_pstate == P_ON);
      BATTERY_DRAW_EN   <= (nxt_pstate == P_ON);
      SDA_OUT           <= 1'b0; // open drain: only ever pulls low
    end
  end

endmodule // wmpd_top
